// ==== hw/fptx_cfg.svh ====
// Offsets, field positions, reset values and code constants of the transmit path.
// Assumes inclusion by bare name from the transmit path design files.
`ifndef FPTX_CFG_SVH
`define FPTX_CFG_SVH

// Register byte offsets
`define FPTX_OFS_MODE       8'h00
`define FPTX_OFS_INTCOND    8'h08
`define FPTX_OFS_TXSTATE    8'h10
`define FPTX_OFS_INJTHR     8'h14
`define FPTX_OFS_INJSYM1    8'h18
`define FPTX_OFS_INJSYM2    8'h1c
`define FPTX_OFS_INJCTRL    8'h20
`define FPTX_OFS_STATUS     8'h24

// Field positions
`define FPTX_MODE_RUN_BIT   0
`define FPTX_MODE_NRZ_BIT   6
`define FPTX_TSR_TM_LSB     0
`define FPTX_TSR_SE_BIT     3
`define FPTX_TSR_PCE_BIT    6
`define FPTX_ICR_DPE_BIT    0

// Reset values
`define FPTX_MODE_RST       8'h00
`define FPTX_TSR_RST        8'h00
`define FPTX_INJTHR_RST     8'h00
`define FPTX_INJSYM_RST     5'h00
`define FPTX_INJCTRL_RST    2'h0

// Transmit mode codes
`define FPTX_TM_OFF         3'h0
`define FPTX_TM_IDLE        3'h1
`define FPTX_TM_MASTER      3'h2
`define FPTX_TM_QUIET       3'h3
`define FPTX_TM_ACTIVE      3'h4
`define FPTX_TM_HALT        3'h5

// Injection control codes
`define FPTX_IC_NONE        2'h0
`define FPTX_IC_ONESHOT     2'h1
`define FPTX_IC_PERIODIC    2'h2
`define FPTX_IC_CONT        2'h3

// Line symbols
`define FPTX_SYM_IDLE       5'h1f
`define FPTX_SYM_HALT       5'h04
`define FPTX_SYM_QUIET      5'h00
`define FPTX_SYM_J          5'h18
`define FPTX_SYM_K          5'h11
`define FPTX_SYM_T          5'h0d
`define FPTX_SYM_R          5'h07
`define FPTX_SYM_S          5'h19
`define FPTX_SYM_VIOL       5'h01

// Timing counts
`define FPTX_PAIR_BITS      4'h9
`define FPTX_PREAMBLE_AIM   4'h7
`define FPTX_PRE_CNT_MAX    4'hf

`endif

// ==== hw/fptx_pkg.sv ====
// Types shared by the transmit path.
// Assumes nothing beyond a SystemVerilog compiler.
package fptx_pkg;

    typedef enum logic [2:0] {
        FPTX_CL_DATA, FPTX_CL_J, FPTX_CL_K, FPTX_CL_T,
        FPTX_CL_R, FPTX_CL_S, FPTX_CL_I, FPTX_CL_V
    } fptx_class_t;

    typedef enum logic [2:0] {
        FPTX_RF_REPEAT, FPTX_RF_HALT1, FPTX_RF_HALT2, FPTX_RF_IDLE, FPTX_RF_END
    } fptx_rf_state_t;

    typedef enum logic {
        FPTX_SM_PASS, FPTX_SM_EXTEND
    } fptx_sm_state_t;

endpackage

// ==== hw/fptx_top.sv ====
// FDDI transmit path: encoder, repeat filter, smoother, line state generator,
// injection, serialiser and NRZI encoder, with an APB register slave.
// Assumes upstream bytes on the same clock, held until the take pulse.
// Function
// - Data nibbles 0 to 7 map to their fixed 5-bit codes.
// - Data nibbles 8 to F map to their fixed 5-bit codes.
// - Control 1101 gives J then K, 0100/0101 give T, 0110 gives R.
// - Violation in repeat gives two Halt pairs, then idle state.
// - Idle pairs send the filter to idle until a JK arrives.
// - A JK pair returns the filter to repeat from any state.
// - End state: R or S before T is a violation, nT ends frame.
// - Smoother aims at seven idle pairs, deletes one at seven or more, in extend state only.
// - Smoother inserts one idle pair below seven via extend state.
// - Preamble counter starts on idle pair, clears to zero on JK pair.
// - Transmit mode field bits 2:0 override filter output when not active.
// - Active sends data; idle, master, quiet, halt send their pairs.
// - Off sends quiet and drops PMD enable; reserved sends quiet.
// - Injected pair beats generator, filter and smoother.
// - Injection control selects none, one-shot, periodic or continuous.
// - One-shot injects once on byte n after JK; n zero replaces JK.
// - Periodic injects every (n+1)th symbol pair; n zero replaces all.
// - Continuous replaces every pair, like periodic with zero threshold.
// - Injection threshold is eight bits, at most 255.
// - Pair loads on the byte boundary and shifts out bit by bit.
// - Mode bit 6 low gives NRZI, high gives plain NRZ.
// - Enabled parity failure sets the error flag and acts as violation.
`include "fptx_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module fptx_top (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Upstream byte stream
    input wire logic [9:0] TX_BYTE,
    output logic TX_BYTE_TAKEN,
    // PMD transmitter
    output logic TX_SERIAL,
    output logic TX_PMD_ENABLE
);
    import fptx_pkg::*;

    // Reset release
    logic rst_meta_n_reg;
    logic rst_n_reg;
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta_n_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_meta_n_reg <= 1'b1;
            rst_n_reg <= rst_meta_n_reg;
        end
    end

    // Registers
    logic [7:0] mode_register_reg;
    logic [7:0] transmit_state_register_reg;
    logic [7:0] injection_threshold_reg;
    logic [4:0] injection_symbol_first_reg;
    logic [4:0] injection_symbol_second_reg;
    logic [1:0] injection_control_field_reg;
    logic data_parity_error_flag_reg;

    // Datapath state
    logic [3:0] bit_cnt_reg;
    logic [9:0] in_byte_reg;
    logic [9:0] shift_reg;
    logic nrzi_reg;
    logic pmd_en_reg;
    fptx_rf_state_t rf_state_reg;
    fptx_rf_state_t rf_state_next;
    fptx_sm_state_t sm_state_reg;
    fptx_sm_state_t sm_state_next;
    logic [9:0] sm_held_reg;
    logic [3:0] pre_cnt_reg;
    logic prev_idle_reg;
    logic [7:0] inj_cnt_reg;
    logic oneshot_armed_reg;

    // APB decode
    wire apb_access = PSEL && PENABLE;
    wire apb_wr = apb_access && PWRITE;
    wire sel_mode = (PADDR == `FPTX_OFS_MODE);
    wire sel_icr = (PADDR == `FPTX_OFS_INTCOND);
    wire sel_tsr = (PADDR == `FPTX_OFS_TXSTATE);
    wire sel_thr = (PADDR == `FPTX_OFS_INJTHR);
    wire sel_sym1 = (PADDR == `FPTX_OFS_INJSYM1);
    wire sel_sym2 = (PADDR == `FPTX_OFS_INJSYM2);
    wire sel_ictl = (PADDR == `FPTX_OFS_INJCTRL);
    wire sel_stat = (PADDR == `FPTX_OFS_STATUS);
    wire sel_any = sel_mode | sel_icr | sel_tsr | sel_thr | sel_sym1 | sel_sym2 | sel_ictl | sel_stat;

    assign PREADY = 1'b1;
    assign PSLVERR = apb_access && !sel_any;
    assign PRDATA = sel_mode ? {24'h000000, mode_register_reg} :
                    sel_icr ? {31'h00000000, data_parity_error_flag_reg} :
                    sel_tsr ? {24'h000000, transmit_state_register_reg} :
                    sel_thr ? {24'h000000, injection_threshold_reg} :
                    sel_sym1 ? {27'h0000000, injection_symbol_first_reg} :
                    sel_sym2 ? {27'h0000000, injection_symbol_second_reg} :
                    sel_ictl ? {30'h00000000, injection_control_field_reg} :
                    sel_stat ? {16'h0000, pre_cnt_reg, 3'h0, sm_state_reg, 5'h00, rf_state_reg} :
                    32'h00000000;

    // Control fields
    wire [2:0] transmit_mode_field = transmit_state_register_reg[`FPTX_TSR_TM_LSB +: 3];
    wire smoother_enable = transmit_state_register_reg[`FPTX_TSR_SE_BIT];
    wire parity_check_enable = transmit_state_register_reg[`FPTX_TSR_PCE_BIT];
    wire plain_nrz_select = mode_register_reg[`FPTX_MODE_NRZ_BIT];
    wire run = mode_register_reg[`FPTX_MODE_RUN_BIT];
    wire tm_active = (transmit_mode_field == `FPTX_TM_ACTIVE);
    wire force_idle = !run || !tm_active;

    // Byte boundary
    wire pair_edge = (bit_cnt_reg == `FPTX_PAIR_BITS);
    assign TX_BYTE_TAKEN = pair_edge;

    // Nibble encoder
    function automatic logic [7:0] enc_nibble(input logic [3:0] nib, input logic ctl, input logic hi);
        logic [7:0] r;
        r = {FPTX_CL_DATA, `FPTX_SYM_QUIET};
        if (!ctl) begin
            case (nib)
                4'h0: r = {FPTX_CL_DATA, 5'h1e};
                4'h1: r = {FPTX_CL_DATA, 5'h09};
                4'h2: r = {FPTX_CL_DATA, 5'h14};
                4'h3: r = {FPTX_CL_DATA, 5'h15};
                4'h4: r = {FPTX_CL_DATA, 5'h0a};
                4'h5: r = {FPTX_CL_DATA, 5'h0b};
                4'h6: r = {FPTX_CL_DATA, 5'h0e};
                4'h7: r = {FPTX_CL_DATA, 5'h0f};
                4'h8: r = {FPTX_CL_DATA, 5'h12};
                4'h9: r = {FPTX_CL_DATA, 5'h13};
                4'ha: r = {FPTX_CL_DATA, 5'h16};
                4'hb: r = {FPTX_CL_DATA, 5'h17};
                4'hc: r = {FPTX_CL_DATA, 5'h1a};
                4'hd: r = {FPTX_CL_DATA, 5'h1b};
                4'he: r = {FPTX_CL_DATA, 5'h1c};
                default: r = {FPTX_CL_DATA, 5'h1d};
            endcase
        end else begin
            case (nib)
                4'hd: r = hi ? {FPTX_CL_J, `FPTX_SYM_J} : {FPTX_CL_K, `FPTX_SYM_K};
                4'h4: r = {FPTX_CL_T, `FPTX_SYM_T};
                4'h5: r = {FPTX_CL_T, `FPTX_SYM_T};
                4'h6: r = {FPTX_CL_R, `FPTX_SYM_R};
                4'h7: r = {FPTX_CL_S, `FPTX_SYM_S};
                4'h0: r = {FPTX_CL_I, `FPTX_SYM_IDLE};
                default: r = {FPTX_CL_V, `FPTX_SYM_VIOL};
            endcase
        end
        return r;
    endfunction

    // Encode and classify current pair
    wire [7:0] enc_hi = enc_nibble(in_byte_reg[7:4], in_byte_reg[8], 1'b1);
    wire [7:0] enc_lo = enc_nibble(in_byte_reg[3:0], in_byte_reg[8], 1'b0);
    wire [2:0] cl_hi = enc_hi[7:5];
    wire [2:0] cl_lo = enc_lo[7:5];
    wire [9:0] enc_pair = {enc_hi[4:0], enc_lo[4:0]};
    wire parity_err = parity_check_enable && !(^in_byte_reg);
    wire is_jk = (cl_hi == FPTX_CL_J) && (cl_lo == FPTX_CL_K);
    wire is_ii = (cl_hi == FPTX_CL_I) && (cl_lo == FPTX_CL_I);
    wire bad_sym = (cl_hi == FPTX_CL_V) || (cl_lo == FPTX_CL_V) ||
                   (!is_jk && ((cl_hi == FPTX_CL_J) || (cl_lo == FPTX_CL_K) ||
                               (cl_hi == FPTX_CL_K) || (cl_lo == FPTX_CL_J)));
    wire is_viol = bad_sym || parity_err;
    wire ends_frame = (cl_hi == FPTX_CL_T) || ((cl_hi == FPTX_CL_DATA) && (cl_lo == FPTX_CL_T));
    wire has_rs = (cl_hi == FPTX_CL_R) || (cl_hi == FPTX_CL_S) ||
                  (cl_lo == FPTX_CL_R) || (cl_lo == FPTX_CL_S);

    localparam logic [9:0] PAIR_IDLE = {`FPTX_SYM_IDLE, `FPTX_SYM_IDLE};
    localparam logic [9:0] PAIR_HALT = {`FPTX_SYM_HALT, `FPTX_SYM_HALT};
    localparam logic [9:0] PAIR_QUIET = {`FPTX_SYM_QUIET, `FPTX_SYM_QUIET};
    localparam logic [9:0] PAIR_MASTER = {`FPTX_SYM_HALT, `FPTX_SYM_QUIET};

    // Repeat filter
    logic [9:0] rf_pair;
    always_comb begin
        rf_state_next = rf_state_reg;
        rf_pair = enc_pair;
        if (force_idle) begin
            rf_state_next = FPTX_RF_IDLE;
            rf_pair = PAIR_IDLE;
        end else if (is_jk) begin
            rf_state_next = FPTX_RF_REPEAT;
        end else begin
            case (rf_state_reg)
                FPTX_RF_REPEAT: begin
                    if (is_ii) begin
                        rf_state_next = FPTX_RF_IDLE;
                        rf_pair = PAIR_IDLE;
                    end else if (is_viol) begin
                        rf_state_next = FPTX_RF_HALT1;
                        rf_pair = PAIR_HALT;
                    end else if (ends_frame) begin
                        rf_state_next = FPTX_RF_END;
                    end else if (has_rs) begin
                        rf_state_next = FPTX_RF_HALT1;
                        rf_pair = PAIR_HALT;
                    end
                end
                FPTX_RF_END: begin
                    if (is_ii) begin
                        rf_state_next = FPTX_RF_IDLE;
                        rf_pair = PAIR_IDLE;
                    end else if (is_viol) begin
                        rf_state_next = FPTX_RF_HALT1;
                        rf_pair = PAIR_HALT;
                    end
                end
                FPTX_RF_HALT1: begin
                    rf_state_next = is_ii ? FPTX_RF_IDLE : FPTX_RF_HALT2;
                    rf_pair = is_ii ? PAIR_IDLE : PAIR_HALT;
                end
                FPTX_RF_HALT2: begin
                    rf_state_next = FPTX_RF_IDLE;
                    rf_pair = PAIR_IDLE;
                end
                FPTX_RF_IDLE: begin
                    rf_pair = PAIR_IDLE;
                end
                default: begin
                    rf_state_next = FPTX_RF_IDLE;
                    rf_pair = PAIR_IDLE;
                end
            endcase
        end
    end

    // Smoother
    wire rf_idle = (rf_pair == PAIR_IDLE);
    wire rf_jk = !force_idle && is_jk;
    wire held_idle = (sm_held_reg == PAIR_IDLE);
    logic [9:0] sm_pair;
    logic [3:0] pre_cnt_next;
    always_comb begin
        sm_state_next = sm_state_reg;
        sm_pair = rf_pair;
        case (sm_state_reg)
            FPTX_SM_PASS: begin
                if (rf_jk && smoother_enable && (pre_cnt_reg < `FPTX_PREAMBLE_AIM)) begin
                    sm_state_next = FPTX_SM_EXTEND;
                    sm_pair = PAIR_IDLE;
                end
            end
            FPTX_SM_EXTEND: begin
                if (held_idle && rf_idle && (pre_cnt_reg >= `FPTX_PREAMBLE_AIM)) begin
                    sm_state_next = FPTX_SM_PASS;
                    sm_pair = rf_pair;
                end else begin
                    sm_pair = sm_held_reg;
                end
            end
            default: begin
                sm_state_next = FPTX_SM_PASS;
                sm_pair = rf_pair;
            end
        endcase
        if (rf_jk) begin
            pre_cnt_next = 4'h0;
        end else if (rf_idle) begin
            pre_cnt_next = !prev_idle_reg ? 4'h1 :
                           (pre_cnt_reg == `FPTX_PRE_CNT_MAX) ? pre_cnt_reg : pre_cnt_reg + 4'h1;
        end else begin
            pre_cnt_next = pre_cnt_reg;
        end
    end

    // Line state generator
    logic [9:0] lsg_pair;
    always_comb begin
        case (transmit_mode_field)
            `FPTX_TM_ACTIVE: lsg_pair = sm_pair;
            `FPTX_TM_IDLE: lsg_pair = PAIR_IDLE;
            `FPTX_TM_MASTER: lsg_pair = PAIR_MASTER;
            `FPTX_TM_QUIET: lsg_pair = PAIR_QUIET;
            `FPTX_TM_HALT: lsg_pair = PAIR_HALT;
            default: lsg_pair = PAIR_QUIET;
        endcase
    end

    // Injection control
    wire lsg_jk = tm_active && (lsg_pair == {`FPTX_SYM_J, `FPTX_SYM_K});
    wire [7:0] injection_threshold = injection_threshold_reg;
    logic inject;
    logic [7:0] inj_cnt_next;
    logic oneshot_armed_next;
    always_comb begin
        inject = 1'b0;
        inj_cnt_next = inj_cnt_reg;
        oneshot_armed_next = oneshot_armed_reg;
        case (injection_control_field_reg)
            `FPTX_IC_ONESHOT: begin
                if (lsg_jk) begin
                    inject = (injection_threshold == 8'h00);
                    oneshot_armed_next = (injection_threshold != 8'h00);
                    inj_cnt_next = 8'h01;
                end else if (oneshot_armed_reg) begin
                    inject = (inj_cnt_reg == injection_threshold);
                    oneshot_armed_next = !inject;
                    inj_cnt_next = inj_cnt_reg + 8'h01;
                end
            end
            `FPTX_IC_PERIODIC: begin
                inject = (inj_cnt_reg >= injection_threshold);
                inj_cnt_next = inject ? 8'h00 : inj_cnt_reg + 8'h01;
            end
            `FPTX_IC_CONT: begin
                inject = 1'b1;
                inj_cnt_next = 8'h00;
            end
            default: begin
                inj_cnt_next = 8'h00;
                oneshot_armed_next = 1'b0;
            end
        endcase
    end
    wire [9:0] tx_pair = inject ? {injection_symbol_first_reg, injection_symbol_second_reg} : lsg_pair;

    // Register writes
    always_ff @(posedge REF_CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            mode_register_reg <= `FPTX_MODE_RST;
            transmit_state_register_reg <= `FPTX_TSR_RST;
            injection_threshold_reg <= `FPTX_INJTHR_RST;
            injection_symbol_first_reg <= `FPTX_INJSYM_RST;
            injection_symbol_second_reg <= `FPTX_INJSYM_RST;
            injection_control_field_reg <= `FPTX_INJCTRL_RST;
        end else if (apb_wr) begin
            if (sel_mode) mode_register_reg <= PWDATA[7:0];
            if (sel_tsr) transmit_state_register_reg <= PWDATA[7:0];
            if (sel_thr) injection_threshold_reg <= PWDATA[7:0];
            if (sel_sym1) injection_symbol_first_reg <= PWDATA[4:0];
            if (sel_sym2) injection_symbol_second_reg <= PWDATA[4:0];
            if (sel_ictl) injection_control_field_reg <= PWDATA[1:0];
        end
    end

    // Parity error flag, write one to clear, set wins
    wire dpe_set = pair_edge && parity_err;
    wire dpe_clr = apb_wr && sel_icr && PWDATA[`FPTX_ICR_DPE_BIT];
    always_ff @(posedge REF_CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            data_parity_error_flag_reg <= 1'b0;
        end else begin
            data_parity_error_flag_reg <= dpe_set || (data_parity_error_flag_reg && !dpe_clr);
        end
    end

    // Byte pipeline state
    always_ff @(posedge REF_CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            in_byte_reg <= {2'b10, 8'h00};
            rf_state_reg <= FPTX_RF_IDLE;
            sm_state_reg <= FPTX_SM_PASS;
            sm_held_reg <= PAIR_IDLE;
            pre_cnt_reg <= 4'h0;
            prev_idle_reg <= 1'b0;
            inj_cnt_reg <= 8'h00;
            oneshot_armed_reg <= 1'b0;
            pmd_en_reg <= 1'b0;
        end else if (pair_edge) begin
            in_byte_reg <= TX_BYTE;
            rf_state_reg <= rf_state_next;
            sm_state_reg <= sm_state_next;
            sm_held_reg <= rf_pair;
            pre_cnt_reg <= pre_cnt_next;
            prev_idle_reg <= rf_idle;
            inj_cnt_reg <= inj_cnt_next;
            oneshot_armed_reg <= oneshot_armed_next;
            pmd_en_reg <= (transmit_mode_field != `FPTX_TM_OFF);
        end
    end

    // Serialiser and line encoder
    wire ser_bit = shift_reg[9];
    always_ff @(posedge REF_CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            bit_cnt_reg <= 4'h0;
            shift_reg <= PAIR_QUIET;
            nrzi_reg <= 1'b0;
        end else begin
            bit_cnt_reg <= pair_edge ? 4'h0 : bit_cnt_reg + 4'h1;
            shift_reg <= pair_edge ? tx_pair : {shift_reg[8:0], 1'b0};
            nrzi_reg <= plain_nrz_select ? ser_bit : (nrzi_reg ^ ser_bit);
        end
    end

    assign TX_SERIAL = nrzi_reg;
    assign TX_PMD_ENABLE = pmd_en_reg;

endmodule

`default_nettype wire

// ==== sim/fptx_chk.sv ====
// Port checker for the transmit path.
// Assumes binding onto fptx_top.
`timescale 1ns/1ps
`default_nettype none
module fptx_chk (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // Register writes
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    // Stream and line
    input wire logic TX_BYTE_TAKEN,
    input wire logic TX_SERIAL,
    input wire logic TX_PMD_ENABLE
);
    logic [2:0] tm_reg;
    logic nrz_reg;
    logic [1:0] ic_reg;
    logic [5:0] age_reg;
    logic wr;
    logic settled;
    assign wr = PSEL && PENABLE && PWRITE;
    assign settled = (age_reg == 6'h28) && (ic_reg == 2'h0);
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            tm_reg <= 3'h0;
            nrz_reg <= 1'b0;
            ic_reg <= 2'h0;
            age_reg <= 6'h0;
        end else begin
            if (wr && PADDR == 8'h10) tm_reg <= PWDATA[2:0];
            if (wr && PADDR == 8'h00) nrz_reg <= PWDATA[6];
            if (wr && PADDR == 8'h20) ic_reg <= PWDATA[1:0];
            age_reg <= wr ? 6'h0 : (settled || age_reg == 6'h28) ? age_reg : age_reg + 6'h1;
        end
    end
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    property p_taken_period;
        TX_BYTE_TAKEN |=> !TX_BYTE_TAKEN [*8] ##1 !TX_BYTE_TAKEN ##1 TX_BYTE_TAKEN;
    endproperty
    a_taken_period: assert property (p_taken_period) else $error("byte take spacing wrong");
    property p_pmd_mode;
        TX_BYTE_TAKEN |=> TX_PMD_ENABLE == ($past(tm_reg) != 3'h0);
    endproperty
    a_pmd_mode: assert property (p_pmd_mode) else $error("transmitter enable wrong for mode");
    property p_pmd_hold;
        $changed(TX_PMD_ENABLE) |-> $past(TX_BYTE_TAKEN);
    endproperty
    a_pmd_hold: assert property (p_pmd_hold) else $error("enable moved off byte boundary");
    property p_idle_nrz;
        settled && tm_reg == 3'h1 && nrz_reg |-> TX_SERIAL;
    endproperty
    a_idle_nrz: assert property (p_idle_nrz) else $error("idle line not high");
    property p_idle_nrzi;
        settled && tm_reg == 3'h1 && !nrz_reg |-> TX_SERIAL != $past(TX_SERIAL);
    endproperty
    a_idle_nrzi: assert property (p_idle_nrzi) else $error("idle line not toggling");
    property p_quiet;
        settled && tm_reg inside {3'h0, 3'h3, 3'h6, 3'h7} |-> $stable(TX_SERIAL);
    endproperty
    a_quiet: assert property (p_quiet) else $error("quiet line moved");
    property p_halt;
        settled && tm_reg == 3'h5 && nrz_reg && TX_SERIAL |=> !TX_SERIAL [*4] ##1 TX_SERIAL;
    endproperty
    a_halt: assert property (p_halt) else $error("halt pattern wrong");
    property p_reset_low;
        $rose(RST_N) |-> !TX_SERIAL;
    endproperty
    a_reset_low: assert property (p_reset_low) else $error("line not low after reset");
endmodule
bind fptx_top fptx_chk i_fptx_chk (.REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .TX_BYTE_TAKEN(TX_BYTE_TAKEN),
    .TX_SERIAL(TX_SERIAL), .TX_PMD_ENABLE(TX_PMD_ENABLE));
`default_nettype wire

// ==== sim/fptx_pmd_model.sv ====
// Receiving transmitter model: decodes the line into symbol pairs.
// Assumes each pair ends one cycle after the byte boundary.
`timescale 1ns/1ps
`default_nettype none
module fptx_pmd_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Line side
    input wire logic frame_mark,
    input wire logic line_in,
    input wire logic nrz_sel,
    // Decoded pairs
    output logic [9:0] pair_out,
    output logic pair_vld
);
    logic prev_reg, mark_reg;
    logic [8:0] sh_reg;
    logic bit_now;
    assign bit_now = nrz_sel ? line_in : (line_in ^ prev_reg);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_reg <= 1'b0;
            mark_reg <= 1'b0;
            sh_reg <= 9'h0;
            pair_out <= 10'h0;
            pair_vld <= 1'b0;
        end else begin
            prev_reg <= line_in;
            sh_reg <= {sh_reg[7:0], bit_now};
            mark_reg <= frame_mark;
            pair_vld <= mark_reg;
            if (mark_reg) pair_out <= {sh_reg, bit_now};
        end
    end
endmodule
`default_nettype wire

// ==== sim/fptx_tb.sv ====
// Self-checking bench for the transmit path.
// Assumes fptx_top, the line model and the bound checker.
`include "fptx_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic ref_clk, rst_n, psel, penable, pwrite, pslverr, pready, taken, serial, pmd_en, vld, nrz, err;
    logic [7:0] paddr, d;
    logic [31:0] pwdata, prdata, rd;
    logic [9:0] tx_byte, pair, jk;
    logic [10:0] expq[$];
    logic [10:0] e;
    logic [4:0] enc[16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
        5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
    logic [7:0] regs[7] = '{8'h00, 8'h08, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
    integer fail_count = 0, n_tests = 0, seed = 32'hf713, i, m;
    localparam logic [9:0] JKP = {`FPTX_SYM_J, `FPTX_SYM_K};
    localparam logic [9:0] HH = {2{`FPTX_SYM_HALT}};
    fptx_top i_fptx_top (.REF_CLK(ref_clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .TX_BYTE(tx_byte), .TX_BYTE_TAKEN(taken), .TX_SERIAL(serial), .TX_PMD_ENABLE(pmd_en));
    fptx_pmd_model i_fptx_pmd_model (.clk(ref_clk), .rst_n(rst_n), .frame_mark(taken), .line_in(serial),
        .nrz_sel(nrz), .pair_out(pair), .pair_vld(vld));
    function automatic logic [9:0] pb(input logic c, input logic [7:0] v);
        return {~^{c, v}, c, v};
    endfunction
    function automatic logic [9:0] ep(input logic [7:0] v);
        return {enc[v[7:4]], enc[v[3:0]]};
    endfunction
    function automatic logic [9:0] ls(input logic [2:0] t);
        case (t)
            3'h1, 3'h4: return {2{`FPTX_SYM_IDLE}};
            3'h2: return {`FPTX_SYM_HALT, `FPTX_SYM_QUIET};
            3'h5: return HH;
            default: return 10'h0;
        endcase
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic send(input logic [9:0] b, input logic [9:0] x, input integer k);
        do @(posedge ref_clk); while (taken !== 1'b1);
        tx_byte <= b;
        repeat (k) expq.push_back(11'h400);
        expq.push_back({1'b0, x});
    endtask
    task automatic drain();
        while (expq.size() != 0) @(posedge ref_clk);
    endtask
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        if (vld === 1'b1 && expq.size() > 0) begin
            e = expq.pop_front();
            if (!e[10]) chk({22'h0, pair}, {22'h0, e[9:0]});
        end
    end
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        #200000;
        fail_count++;
        results();
    end
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        nrz = 1'b1;
        jk = pb(1'b1, 8'hdd);
        tx_byte = pb(1'b0, 8'h00);
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        for (i = 0; i < 7; i++) begin
            apb(1'b0, regs[i], 32'h0);
            chk(rd, 32'h0);
        end
        apb(1'b0, 8'h04, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, 8'h14, 32'h1ff);
        apb(1'b0, 8'h14, 32'h0);
        chk(rd, 32'hff);
        for (m = 0; m < 16; m++) begin
            apb(1'b1, 8'h00, {25'h0, m[3], 6'h1});
            nrz <= m[3];
            apb(1'b1, 8'h10, {29'h0, m[2:0]});
            send(pb(1'b0, 8'h5a), ls(m[2:0]), 3);
            send(pb(1'b0, 8'h5a), ls(m[2:0]), 0);
            drain();
            chk({31'h0, pmd_en}, {31'h0, m[2:0] != 3'h0});
        end
        for (m = 0; m < 2; m++) begin
            apb(1'b1, 8'h00, {25'h0, m[0], 6'h1});
            nrz <= m[0];
            apb(1'b1, 8'h10, 32'h4);
            send(jk, JKP, 3);
            d = 8'h01;
            for (i = 0; i < 12; i++) begin
                send(pb(1'b0, d), ep(d), 0);
                d = (i < 7) ? d + 8'h22 : 8'($random(seed));
            end
            drain();
        end
        apb(1'b1, 8'h10, 32'h44);
        send(jk, JKP, 3);
        send(pb(1'b0, 8'h12), ep(8'h12), 0);
        send(pb(1'b0, 8'h12) ^ 10'h200, HH, 0);
        send(pb(1'b0, 8'h34), HH, 0);
        send(pb(1'b0, 8'h56), {2{`FPTX_SYM_IDLE}}, 0);
        send(jk, JKP, 0);
        send(pb(1'b0, 8'h78), ep(8'h78), 0);
        drain();
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, 8'h08, 32'h1);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 8'h18, 32'h15);
        apb(1'b1, 8'h1c, 32'h0a);
        for (m = 0; m < 4; m++) begin
            apb(1'b1, 8'h14, (m == 0) ? 32'h2 : 32'h0);
            apb(1'b1, 8'h20, (m < 2) ? 32'h1 : m);
            send(jk, (m > 0) ? 10'h2aa : JKP, 3);
            for (i = 1; i < 5; i++) send(pb(1'b0, 8'h9c), (m > 1 || (m == 0 && i == 2)) ? 10'h2aa : ep(8'h9c), 0);
            drain();
        end
        apb(1'b1, 8'h20, 32'h0);
        send(jk, JKP, 3);
        drain();
        results();
    end
endmodule
`default_nettype wire
